// ### src/tcpr_pin_router.sv
// timer channel 8..15 pin router with its two select registers on AXI4-Lite
//
// How it works
// - ch9 A input select: 00/01 pin 0, 10 pin 1, 11 pin 2; resets 00.
// - ch8 B input select at bits 5:4 picks pin 0,0,1,2; resets 00.
// - ch8 A output select: 00 no pin (reset), 01..11 pins 0..2.
// - reserved bits always read zero; software writes zeros there.
// - even channels route A as output only; odd ones input or output.
// - B signals only come in from pins, never driven out.
// - odd channel with nonzero A output select ignores its A input select.
// - selected pins need analog off, peripheral function on; direction ignored.
// - an input pin carries back whatever another function drives on it.
// - select registers keep their contents across deep standby reset.
// - ch12..15 register field layout as per the fixed bit positions.
// - ch15 A output select: 00 none (reset), 01..11 pins 0..2.
// - ch15 A input select: 00/01 pin 0, 10 pin 1, 11 pin 2; resets 00.
// - ch13..15 B input selects pick pin 0,0,1,2; each resets 00.
// - ch14 A output select: 00 disabled (reset), 01..11 pins 0..2.
// - ch13 A output select: 00 disabled (reset), 01..11 pins 0..2.
// - reads return the last written value with no routing side effect.
// - ch13 A input select at bits 9:8 picks pin 0,0,1,2; resets 00.
// - ch12 B input select at bits 5:4 picks pin 0,0,1,2; resets 00.
// - ch12 A output select: 00 disabled (reset), 01..11 pins 0..2.
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
module tcpr_pin_router (
   input  logic                                        clk_sys_i,
   input  logic                                        resetn_i,
   input  logic                                        dstby_resetn_i,
   input  logic [tcpr_pkg::TCPR_AW-1:0]                s_axi_awaddr_i,
   input  logic                                        s_axi_awvalid_i,
   output logic                                        s_axi_awready_o,
   input  logic [tcpr_pkg::TCPR_DW-1:0]                s_axi_wdata_i,
   input  logic [3:0]                                  s_axi_wstrb_i,
   input  logic                                        s_axi_wvalid_i,
   output logic                                        s_axi_wready_o,
   output logic [1:0]                                  s_axi_bresp_o,
   output logic                                        s_axi_bvalid_o,
   input  logic                                        s_axi_bready_i,
   input  logic [tcpr_pkg::TCPR_AW-1:0]                s_axi_araddr_i,
   input  logic                                        s_axi_arvalid_i,
   output logic                                        s_axi_arready_o,
   output logic [tcpr_pkg::TCPR_DW-1:0]                s_axi_rdata_o,
   output logic [1:0]                                  s_axi_rresp_o,
   output logic                                        s_axi_rvalid_o,
   input  logic                                        s_axi_rready_i,
   input  logic [tcpr_pkg::TCPR_NCH-1:0]               tmr_a_out_i,
   output logic [tcpr_pkg::TCPR_NCH-1:0]               tmr_a_in_o,
   output logic [tcpr_pkg::TCPR_NCH-1:0]               tmr_b_in_o,
   input  logic [tcpr_pkg::TCPR_NCH-1:0][2:0]          pin_a_i,
   output logic [tcpr_pkg::TCPR_NCH-1:0][2:0]          pin_a_o,
   output logic [tcpr_pkg::TCPR_NCH-1:0][2:0]          pin_a_oe_n_o,
   input  logic [tcpr_pkg::TCPR_NCH-1:0][2:0]          pin_b_i
);
   import tcpr_pkg::*;

   typedef struct packed {
      logic [31:0]         sel_lo;
      logic [31:0]         sel_hi;
      tcpr_wr_t            wr_st;
      tcpr_rd_t            rd_st;
      logic                aw_got;
      logic                w_got;
      logic [TCPR_AW-1:0]  aw_addr;
      logic [31:0]         w_data;
      logic [3:0]          w_strb;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [1:0]          rresp;
      logic [31:0]         rdata;
      logic [7:0][2:0]     pin_a;
      logic [7:0][2:0]     pin_oe_n;
      logic [7:0]          tmr_a_in;
      logic [7:0]          tmr_b_in;
   } tcpr_state_t;

   localparam tcpr_state_t TCPR_RST = '{
      sel_lo:   TCPR_SEL_RST,
      sel_hi:   TCPR_SEL_RST,
      wr_st:    TCPR_WR_IDLE,
      rd_st:    TCPR_RD_IDLE,
      aw_got:   1'b0,
      w_got:    1'b0,
      aw_addr:  '0,
      w_data:   '0,
      w_strb:   '0,
      awready:  1'b1,
      wready:   1'b1,
      bvalid:   1'b0,
      bresp:    TCPR_RESP_OKAY,
      arready:  1'b1,
      rvalid:   1'b0,
      rresp:    TCPR_RESP_OKAY,
      rdata:    '0,
      pin_a:    '0,
      pin_oe_n: '1,
      tmr_a_in: '0,
      tmr_b_in: '0
   };

   tcpr_state_t q;
   tcpr_state_t next_q;

   always_comb begin
      logic [31:0] sel;
      logic [1:0]  a_out;
      logic [1:0]  a_in;
      logic [1:0]  b_in;
      logic [2:0]  oh;
      int          base;
      sel    = '0;
      a_out  = '0;
      a_in   = '0;
      b_in   = '0;
      oh     = '0;
      base   = 0;
      next_q = q;

      // write path: address and data may arrive in either order
      case (q.wr_st)
         TCPR_WR_IDLE: begin
            if (s_axi_awvalid_i && q.awready) begin
               next_q.aw_got  = 1'b1;
               next_q.aw_addr = s_axi_awaddr_i;
               next_q.awready = 1'b0;
            end
            if (s_axi_wvalid_i && q.wready) begin
               next_q.w_got  = 1'b1;
               next_q.w_data = s_axi_wdata_i;
               next_q.w_strb = s_axi_wstrb_i;
               next_q.wready = 1'b0;
            end
            if (q.aw_got && q.w_got) begin
               next_q.bresp = TCPR_RESP_OKAY;
               case (q.aw_addr)
                  TCPR_SEL_LO_OFS: begin
                     next_q.sel_lo = tcpr_merge(q.sel_lo, q.w_data, q.w_strb);
                  end
                  TCPR_SEL_HI_OFS: begin
                     next_q.sel_hi = tcpr_merge(q.sel_hi, q.w_data, q.w_strb);
                  end
                  default: begin
                     next_q.bresp = TCPR_RESP_SLVERR;
                  end
               endcase
               next_q.aw_got = 1'b0;
               next_q.w_got  = 1'b0;
               next_q.bvalid = 1'b1;
               next_q.wr_st  = TCPR_WR_RESP;
            end
         end
         TCPR_WR_RESP: begin
            if (s_axi_bready_i) begin
               next_q.bvalid  = 1'b0;
               next_q.awready = 1'b1;
               next_q.wready  = 1'b1;
               next_q.wr_st   = TCPR_WR_IDLE;
            end
         end
         default: begin
            next_q.wr_st = TCPR_WR_IDLE;
         end
      endcase

      // read path: plain register read, nothing else moves
      case (q.rd_st)
         TCPR_RD_IDLE: begin
            if (s_axi_arvalid_i && q.arready) begin
               next_q.arready = 1'b0;
               next_q.rvalid  = 1'b1;
               next_q.rd_st   = TCPR_RD_RESP;
               next_q.rresp   = TCPR_RESP_OKAY;
               case (s_axi_araddr_i)
                  TCPR_SEL_LO_OFS: next_q.rdata = q.sel_lo;
                  TCPR_SEL_HI_OFS: next_q.rdata = q.sel_hi;
                  default: begin
                     next_q.rdata = '0;
                     next_q.rresp = TCPR_RESP_SLVERR;
                  end
               endcase
            end
         end
         TCPR_RD_RESP: begin
            if (s_axi_rready_i) begin
               next_q.rvalid  = 1'b0;
               next_q.arready = 1'b1;
               next_q.rd_st   = TCPR_RD_IDLE;
            end
         end
         default: begin
            next_q.rd_st = TCPR_RD_IDLE;
         end
      endcase

      // routing uses the settled registers, so a write shows one cycle later
      for (int i = 0; i < TCPR_NCH; i++) begin
         sel   = (i < TCPR_CH_PER_REG) ? q.sel_lo : q.sel_hi;
         base  = (i % TCPR_CH_PER_REG) * TCPR_CH_STRIDE;
         a_out = sel[base + TCPR_A_OUT_LSB +: 2];
         a_in  = sel[base + TCPR_A_IN_LSB +: 2];
         b_in  = sel[base + TCPR_B_IN_LSB +: 2];
         oh    = tcpr_out_onehot(a_out);
         // pin direction comes from the select alone
         next_q.pin_a[i]    = oh & {3{tmr_a_out_i[i]}};
         next_q.pin_oe_n[i] = ~oh;
         // B pins feed the timer only; there is no B drive path at all
         next_q.tmr_b_in[i] = pin_b_i[i][tcpr_in_idx(b_in)];
         // pin level is passed as seen, so a shared driver loops back
         if ((i % 2 == 1) && (a_out == TCPR_OUT_NONE)) begin
            next_q.tmr_a_in[i] = pin_a_i[i][tcpr_in_idx(a_in)];
         end else begin
            next_q.tmr_a_in[i] = 1'b0;
         end
      end

      // deep standby reset clears the bus side but leaves the selects
      if (!dstby_resetn_i) begin
         next_q        = TCPR_RST;
         next_q.sel_lo = q.sel_lo;
         next_q.sel_hi = q.sel_hi;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         q <= TCPR_RST;
      end else begin
         q <= next_q;
      end
   end

   assign s_axi_awready_o = q.awready;
   assign s_axi_wready_o  = q.wready;
   assign s_axi_bvalid_o  = q.bvalid;
   assign s_axi_bresp_o   = q.bresp;
   assign s_axi_arready_o = q.arready;
   assign s_axi_rvalid_o  = q.rvalid;
   assign s_axi_rresp_o   = q.rresp;
   assign s_axi_rdata_o   = q.rdata;
   assign pin_a_o         = q.pin_a;
   assign pin_a_oe_n_o    = q.pin_oe_n;
   assign tmr_a_in_o      = q.tmr_a_in;
   assign tmr_b_in_o      = q.tmr_b_in;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i || !dstby_resetn_i);

   ch9_ain_route_a: assert property (
      q.sel_lo[11:10] == 2'h0 && q.sel_lo[9:8] == 2'h2
      |=> tmr_a_in_o[1] == $past(pin_a_i[1][1]))
      else $error("ch9 A input not taken from pin 1");

   ch8_bin_route_a: assert property (
      q.sel_lo[5:4] == 2'h3 |=> tmr_b_in_o[0] == $past(pin_b_i[0][2]))
      else $error("ch8 B input not taken from pin 2");

   ch8_aout_route_a: assert property (
      q.sel_lo[3:2] == 2'h1
      |=> pin_a_oe_n_o[0] == 3'h6 && pin_a_o[0][0] == $past(tmr_a_out_i[0]))
      else $error("ch8 A output not on pin 0 alone");

   rsvd_zero_a: assert property (
      ((q.sel_lo | q.sel_hi) & ~TCPR_WR_MASK) == 32'h0
      && (!s_axi_rvalid_o || (s_axi_rdata_o & ~TCPR_WR_MASK) == 32'h0))
      else $error("reserved select bits not zero");

   even_a_out_a: assert property (
      (tmr_a_in_o & 8'h55) == 8'h00)
      else $error("even channel A routed as input");

   odd_out_wins_a: assert property (
      q.sel_hi[27:26] != 2'h0 |=> !tmr_a_in_o[7] && pin_a_oe_n_o[7] != 3'h7)
      else $error("ch15 A input not blocked by output select");

   stby_keep_a: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      !dstby_resetn_i |=> q.sel_lo == $past(q.sel_lo) && q.sel_hi == $past(q.sel_hi))
      else $error("select register lost on deep standby reset");

   ch15_ain_route_a: assert property (
      q.sel_hi[27:26] == 2'h0 && q.sel_hi[25:24] == 2'h1
      |=> tmr_a_in_o[7] == $past(pin_a_i[7][0]))
      else $error("ch15 A input not taken from pin 0");

   ch15_bin_route_a: assert property (
      q.sel_hi[29:28] == 2'h2 |=> tmr_b_in_o[7] == $past(pin_b_i[7][1]))
      else $error("ch15 B input not taken from pin 1");

   ch13_aout_route_a: assert property (
      q.sel_hi[11:10] == 2'h3
      |=> pin_a_oe_n_o[5] == 3'h3 && pin_a_o[5][2] == $past(tmr_a_out_i[5]))
      else $error("ch13 A output not on pin 2 alone");

   read_back_a: assert property (
      s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == TCPR_SEL_HI_OFS
      |=> s_axi_rvalid_o && s_axi_rdata_o == $past(q.sel_hi))
      else $error("read did not return the stored select value");

   ch14_idle_pin_a: assert property (
      q.sel_hi[19:18] == 2'h0 |=> pin_a_oe_n_o[6] == 3'h7 && pin_a_o[6] == 3'h0)
      else $error("ch14 A drives a pin while disabled");

   // one code per field, so every decode arm of the router is watched somewhere
   ch8_bin_pin0_a: assert property (
      q.sel_lo[5:4] == 2'h1 |=> tmr_b_in_o[0] == $past(pin_b_i[0][0]))
      else $error("ch8 B input code 01 not taken from pin 0");

   ch11_ain_route_a: assert property (
      q.sel_lo[27:26] == 2'h0 && q.sel_lo[25:24] == 2'h3
      |=> tmr_a_in_o[3] == $past(pin_a_i[3][2]))
      else $error("ch11 A input not taken from pin 2");

   ch8_aout_none_a: assert property (
      q.sel_lo[3:2] == 2'h0
      |=> pin_a_oe_n_o[0] == 3'h7 && pin_a_o[0] == 3'h0)
      else $error("ch8 A drives a pin while disabled");

   ch8_one_pin_a: assert property (
      $onehot0(~pin_a_oe_n_o[0]))
      else $error("ch8 A enabled on more than one pin");

   ch15_aout_route_a: assert property (
      q.sel_hi[27:26] == 2'h2
      |=> pin_a_oe_n_o[7] == 3'h5 && pin_a_o[7][1] == $past(tmr_a_out_i[7]))
      else $error("ch15 A output not on pin 1 alone");

   ch14_aout_route_a: assert property (
      q.sel_hi[19:18] == 2'h1
      |=> pin_a_oe_n_o[6] == 3'h6 && pin_a_o[6][0] == $past(tmr_a_out_i[6]))
      else $error("ch14 A output not on pin 0 alone");

   ch14_bin_route_a: assert property (
      q.sel_hi[21:20] == 2'h3 |=> tmr_b_in_o[6] == $past(pin_b_i[6][2]))
      else $error("ch14 B input not taken from pin 2");

   ch13_bin_route_a: assert property (
      q.sel_hi[13:12] == 2'h2 |=> tmr_b_in_o[5] == $past(pin_b_i[5][1]))
      else $error("ch13 B input not taken from pin 1");

   ch13_ain_route_a: assert property (
      q.sel_hi[11:10] == 2'h0 && q.sel_hi[9:8] == 2'h2
      |=> tmr_a_in_o[5] == $past(pin_a_i[5][1]))
      else $error("ch13 A input not taken from pin 1");

   ch12_bin_route_a: assert property (
      q.sel_hi[5:4] == 2'h2 |=> tmr_b_in_o[4] == $past(pin_b_i[4][1]))
      else $error("ch12 B input not taken from pin 1");

   ch12_aout_route_a: assert property (
      q.sel_hi[3:2] == 2'h3
      |=> pin_a_oe_n_o[4] == 3'h3 && pin_a_o[4][2] == $past(tmr_a_out_i[4]))
      else $error("ch12 A output not on pin 2 alone");

   idle_pin_low_a: assert property (
      (pin_a_o & pin_a_oe_n_o) == 24'h000000)
      else $error("timer level shown on a pin that is not enabled");

   stby_quiet_a: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      !dstby_resetn_i
      |=> pin_a_oe_n_o == {24{1'b1}} && tmr_a_in_o == 8'h00 && !s_axi_bvalid_o)
      else $error("deep standby reset left routing or bus state active");

   reset_sel_a: assert property (
      @(posedge clk_sys_i) disable iff (1'b0)
      !resetn_i |=> q.sel_lo == TCPR_SEL_RST && q.sel_hi == TCPR_SEL_RST)
      else $error("select registers not cleared by full reset");

   read_quiet_a: assert property (
      s_axi_arvalid_i && s_axi_arready_o && !(q.aw_got && q.w_got)
      |=> $stable(q.sel_lo) && $stable(q.sel_hi))
      else $error("read changed a select register");
endmodule : tcpr_pin_router

// ### src/tcpr_pkg.sv
// package: constants, types and helpers for the timer channel pin router
package tcpr_pkg;
   // bus geometry
   localparam int          TCPR_AW          = 8;
   localparam int          TCPR_DW          = 32;
   localparam int          TCPR_NCH         = 8;
   localparam int          TCPR_NALT        = 3;
   // register byte offsets
   localparam logic [7:0]  TCPR_SEL_LO_OFS  = 8'h00;
   localparam logic [7:0]  TCPR_SEL_HI_OFS  = 8'h04;
   // per-channel field layout; channel k of a register starts at k*stride
   localparam int          TCPR_CH_STRIDE   = 8;
   localparam int          TCPR_A_IN_LSB    = 0;
   localparam int          TCPR_A_OUT_LSB   = 2;
   localparam int          TCPR_B_IN_LSB    = 4;
   localparam int          TCPR_CH_PER_REG  = 4;
   // writable bits of both select registers; the rest are reserved
   localparam logic [31:0] TCPR_WR_MASK     = 32'h3F3C3F3C;
   localparam logic [31:0] TCPR_SEL_RST     = 32'h00000000;
   // field encodings
   localparam logic [1:0]  TCPR_OUT_NONE    = 2'h0;
   localparam logic [1:0]  TCPR_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  TCPR_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      TCPR_WR_IDLE = 2'b01,
      TCPR_WR_RESP = 2'b10
   } tcpr_wr_t;

   typedef enum logic [1:0] {
      TCPR_RD_IDLE = 2'b01,
      TCPR_RD_RESP = 2'b10
   } tcpr_rd_t;

   // input select: 00 and 01 both pick alternative pin 0
   function automatic logic [1:0] tcpr_in_idx(input logic [1:0] sel);
      tcpr_in_idx = (sel[1]) ? {1'b0, 1'b1} + {1'b0, sel[0]} : 2'h0;
   endfunction : tcpr_in_idx

   // output select: 00 drives nothing, 01..11 drive pins 0..2
   function automatic logic [2:0] tcpr_out_onehot(input logic [1:0] sel);
      case (sel)
         2'h1:    tcpr_out_onehot = 3'h1;
         2'h2:    tcpr_out_onehot = 3'h2;
         2'h3:    tcpr_out_onehot = 3'h4;
         default: tcpr_out_onehot = 3'h0;
      endcase
   endfunction : tcpr_out_onehot

   // byte-lane merge, reserved bits forced back to zero
   function automatic logic [31:0] tcpr_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] m;
      m = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            m[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      tcpr_merge = m & TCPR_WR_MASK;
   endfunction : tcpr_merge
endpackage : tcpr_pkg

// ### test/tcpr_far_model.sv
// far-side model: base timer A outputs and the alternative port pins
module tcpr_far_model (
   input  wire logic                   clk_sys_i,
   input  wire logic [7:0][2:0]        pin_a_drv_i,
   input  wire logic [7:0][2:0]        pin_a_oe_n_i,
   output wire logic [7:0]             tmr_a_out_o,
   output wire logic [7:0][2:0]        pin_a_lvl_o,
   output wire logic [7:0][2:0]        pin_b_lvl_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int          seed  = 32'hC863;
   logic [7:0]  tmr_a = 8'h00;
   logic [23:0] ext_a = 24'h000000;
   logic [23:0] ext_b = 24'h000000;
   // levels change every cycle so a stale or wrong pick cannot keep matching by chance
   always @(posedge clk_sys_i) begin
      tmr_a <= 8'($random(seed));
      ext_a <= 24'($random(seed));
      ext_b <= 24'($random(seed));
   end
   assign tmr_a_out_o = tmr_a;
   assign pin_b_lvl_o = ext_b;
   // other functions let go of a pin the router drives; elsewhere their level loops back
   assign pin_a_lvl_o = (~pin_a_oe_n_i & pin_a_drv_i)
                      | (pin_a_oe_n_i & ext_a);
endmodule : tcpr_far_model

// ### test/timer_channel_pin_routing_tb.sv
// self-checking bench for the timer channel pin router
module timer_channel_pin_routing_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import tcpr_pkg::*;
   logic clk_sys = 1'b0, resetn = 1'b0, dstby_resetn = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0]  wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, r, d;
   logic [7:0]  tmr_a_out, a_in, b_in, ta_q;
   logic [7:0][2:0] pin_a, pin_b, pa_o, pa_oe_n, pa_q, pb_q;
   logic [1:0]  ao, ai;
   logic [31:0] shadow [2] = '{32'h00000000, 32'h00000000};
   logic [31:0] sh_q [2];
   int num_errors = 0, samples_checked = 0, seed = 32'hC863, skip = 8;

   always #5 clk_sys = ~clk_sys;

   tcpr_pin_router u_dut (.clk_sys_i(clk_sys), .resetn_i(resetn), .dstby_resetn_i(dstby_resetn),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .tmr_a_out_i(tmr_a_out),
      .tmr_a_in_o(a_in), .tmr_b_in_o(b_in), .pin_a_i(pin_a), .pin_a_o(pa_o),
      .pin_a_oe_n_o(pa_oe_n), .pin_b_i(pin_b));

   tcpr_far_model u_far (.clk_sys_i(clk_sys), .pin_a_drv_i(pa_o), .pin_a_oe_n_i(pa_oe_n),
      .tmr_a_out_o(tmr_a_out), .pin_a_lvl_o(pin_a), .pin_b_lvl_o(pin_b));

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (e !== g) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   function automatic logic [1:0] pick(input logic [1:0] s);
      return s[1] ? (s[0] ? 2'h2 : 2'h1) : 2'h0;
   endfunction : pick

   // routing seen in this cycle follows inputs and selects of the cycle before
   always @(negedge clk_sys) begin
      if (!resetn || !dstby_resetn) skip = 2;
      if (skip > 0) skip--;
      else begin
         for (int i = 0; i < 8; i++) begin
            r  = sh_q[i/4];
            ao = r[(i%4)*8+2 +: 2];
            ai = r[(i%4)*8 +: 2];
            cmp("b_in", 32'(pb_q[i][pick(r[(i%4)*8+4 +: 2])]), 32'(b_in[i]));
            cmp("a_in", 32'((i%2 == 1 && ao == 2'h0) ? pa_q[i][pick(ai)] : 1'b0),
                32'(a_in[i]));
            for (int p = 0; p < 3; p++) begin
               cmp("pin_out", 32'((ao == p+1) ? ta_q[i] : 1'b0), 32'(pa_o[i][p]));
               cmp("pin_oe_n", 32'(ao != p+1), 32'(pa_oe_n[i][p]));
            end
         end
      end
      pa_q = pin_a;
      pb_q = pin_b;
      ta_q = tmr_a_out;
      sh_q = shadow;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      skip = 100;
      @(posedge clk_sys);
      awaddr  <= a;
      wdata   <= dv;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge clk_sys);
         if (awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk_sys); while (!bvalid);
      bready <= 1'b0;
      cmp("bresp", 32'((a == 8'h00 || a == 8'h04) ? TCPR_RESP_OKAY : TCPR_RESP_SLVERR),
          32'(bresp));
      if (a == 8'h00 || a == 8'h04) begin
         for (int k = 0; k < 4; k++) if (s[k]) shadow[a[2]][k*8 +: 8] = dv[k*8 +: 8];
         shadow[a[2]] &= TCPR_WR_MASK;
      end
      skip = 3;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clk_sys); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (!rvalid);
      rready <= 1'b0;
      cmp("rdata", (a == 8'h00 || a == 8'h04) ? shadow[a[2]] : 32'h00000000, rdata);
      cmp("rresp", 32'((a == 8'h00 || a == 8'h04) ? TCPR_RESP_OKAY : TCPR_RESP_SLVERR),
          32'(rresp));
   endtask : rd

   task automatic end_sim;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   initial begin
      #200us;
      num_errors++;
      end_sim();
   end

   initial begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(8'h00);
      rd(8'h04);
      // every code in every field, the two registers crossed
      for (int v = 0; v < 4; v++) begin
         wr(8'h00, 32'h55555555 * v, 4'hF);
         wr(8'h04, 32'h55555555 * (3 - v), 4'hF);
         rd(8'h00);
         rd(8'h04);
         repeat (8) @(posedge clk_sys);
      end
      repeat (24) begin
         d = $random(seed);
         wr(8'(($random(seed) & 1) * 4), d, 4'hF);
         rd(8'h00);
         rd(8'h04);
         repeat (4) @(posedge clk_sys);
      end
      // odd A inputs on pins 0, 1 and 2 with their outputs off
      wr(8'h00, 32'h03000200, 4'hF);
      wr(8'h04, 32'h01000200, 4'hF);
      repeat (8) @(posedge clk_sys);
      wr(8'h00, 32'hFFFFFFFF, 4'h2);
      rd(8'h00);
      wr(8'h08, 32'hFFFFFFFF, 4'hF);
      rd(8'h08);
      rd(8'h04);
      // deep standby reset must leave both selects alone
      @(posedge clk_sys);
      dstby_resetn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      dstby_resetn <= 1'b1;
      rd(8'h00);
      rd(8'h04);
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      shadow = '{32'h00000000, 32'h00000000};
      rd(8'h00);
      rd(8'h04);
      repeat (10) @(posedge clk_sys);
      end_sim();
   end
endmodule : timer_channel_pin_routing_tb
